// *** core/drcp_regs.vh ***
// constants for the radial data/clock port and dual-access arbiter
// assumes inclusion by bare name from the design file
`ifndef DRCP_REGS_VH
`define DRCP_REGS_VH
`define DRCP_CLK_HZ 25000000
`define DRCP_WCLK_DIV 4'h4
`define DRCP_DIV_START 4'h0
`define DRCP_DIV_STEP 4'h1
`define DRCP_FIFO_DEPTH 4
`define DRCP_OWN_NONE 2'h0
`define DRCP_OWN_A 2'h1
`define DRCP_OWN_B 2'h2
`endif

// *** core/drcp_top.v ***
// radial cable data/clock path and dual-access request handshake of a disk drive
// assumes all inputs synchronous to I_CLK; the cable driver resolves the
// two-way data pair from O_DATA_OE; servo and recovered timing arrive as strobes
`timescale 1ns/10ps
`include "drcp_regs.vh"

module drcp_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = `DRCP_FIFO_DEPTH,
  parameter AW = 2
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_valid,
  output wire o_ready,
  input wire [WIDTH-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  integer k;
  assign o_ready = (cnt_r != DEPTH);
  assign o_valid = (cnt_r != 0);
  assign o_data = mem_r[rp_r];
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_r[k] <= {WIDTH{1'b0}};
      end
    end else if (i_ce) begin
      if (push) begin
        mem_r[wp_r] <= i_data;
        wp_r <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

module drcp_top #(
  parameter WCLK_DIV = `DRCP_WCLK_DIV
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CE,
  input wire I_WRITE_GATE,
  input wire I_READ_GATE,
  input wire I_SERVO_TICK,
  input wire I_RCVR_TICK,
  input wire I_RCVR_BIT,
  output wire O_RCVR_READY,
  input wire I_DATA,
  output reg O_DATA,
  output reg O_DATA_OE,
  output reg O_CLOCK,
  output reg O_WBIT_VALID,
  output reg O_WBIT,
  input wire I_A_REQUEST_N,
  input wire I_B_REQUEST_N,
  output reg O_PORT_A_OTHER_WANTS_N,
  output reg O_PORT_B_OTHER_WANTS_N,
  output reg O_GRANT_A,
  output reg O_GRANT_B
);
  reg [3:0] div_r;
  reg [1:0] own_r;
  reg [1:0] own_nxt;
  reg last_b_r;
  wire f_valid;
  wire f_data;
  wire clk_rise;
  wire clk_fall;
  wire tick = I_READ_GATE ? I_RCVR_TICK : I_SERVO_TICK;
  // divider position decoded once, shared by toggle and both edge strobes
  wire div_zero = (div_r == `DRCP_DIV_START);
  wire div_last = (div_r == WCLK_DIV - 1);
  // read gate wins the clock, but the pair is only driven with write gate low
  wire rd_drive = I_READ_GATE && !I_WRITE_GATE;
  wire wr_sample = I_WRITE_GATE && !I_READ_GATE;
  wire grant_a_nxt;
  wire grant_b_nxt;

  // owner decode shared by the grant outputs and the tie memory
  function owner_is;
    input [1:0] own;
    input [1:0] who;
    begin
      owner_is = (own == who);
    end
  endfunction

  // recovered bits buffered so the shift-out can wait for a clock fall;
  // a bit that meets a full buffer is lost and not flagged to the controller
  drcp_fifo #(
    .WIDTH(1),
    .DEPTH(`DRCP_FIFO_DEPTH),
    .AW(2)
  ) drcp_fifo_inst (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_valid(I_READ_GATE && I_RCVR_TICK),
    .o_ready(O_RCVR_READY),
    .i_data(I_RCVR_BIT),
    .o_valid(f_valid),
    .i_ready(clk_fall),
    .o_data(f_data)
  );

  // only a tick at divider zero toggles the square wave, so every WCLK_DIV-th tick toggles it
  assign clk_rise = tick && !O_CLOCK && div_zero;
  assign clk_fall = tick && O_CLOCK && div_zero && I_READ_GATE;
  assign grant_a_nxt = owner_is(own_nxt, `DRCP_OWN_A);
  assign grant_b_nxt = owner_is(own_nxt, `DRCP_OWN_B);

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_r <= `DRCP_DIV_START;
      O_CLOCK <= 1'b0;
      O_DATA <= 1'b0;
      O_DATA_OE <= 1'b0;
      O_WBIT_VALID <= 1'b0;
      O_WBIT <= 1'b0;
    end else if (I_CE) begin
      O_WBIT_VALID <= 1'b0;
      O_DATA_OE <= rd_drive;
      if (tick) begin
        div_r <= div_last ? `DRCP_DIV_START : div_r + `DRCP_DIV_STEP;
      end
      if (tick && div_zero) begin
        O_CLOCK <= !O_CLOCK;
      end
      // sample write data at rise, controller moved it at prior rise
      if (clk_rise && wr_sample) begin
        O_WBIT <= I_DATA;
        O_WBIT_VALID <= 1'b1;
      end
      if (clk_fall && f_valid) begin
        O_DATA <= f_data;
      end
    end
  end

  always @* begin
    own_nxt = own_r;
    case (own_r)
      `DRCP_OWN_NONE: begin
        // simultaneous requests alternate so neither side starves
        if (!I_A_REQUEST_N && !I_B_REQUEST_N) begin
          own_nxt = last_b_r ? `DRCP_OWN_A : `DRCP_OWN_B;
        end else if (!I_A_REQUEST_N) begin
          own_nxt = `DRCP_OWN_A;
        end else if (!I_B_REQUEST_N) begin
          own_nxt = `DRCP_OWN_B;
        end
      end
      `DRCP_OWN_A: begin
        if (I_A_REQUEST_N) begin
          own_nxt = `DRCP_OWN_NONE;
        end
      end
      `DRCP_OWN_B: begin
        if (I_B_REQUEST_N) begin
          own_nxt = `DRCP_OWN_NONE;
        end
      end
      default: begin
        own_nxt = `DRCP_OWN_NONE;
      end
    endcase
  end

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      own_r <= `DRCP_OWN_NONE;
      last_b_r <= 1'b0;
      O_GRANT_A <= 1'b0;
      O_GRANT_B <= 1'b0;
      O_PORT_A_OTHER_WANTS_N <= 1'b1;
      O_PORT_B_OTHER_WANTS_N <= 1'b1;
    end else if (I_CE) begin
      own_r <= own_nxt;
      if (grant_b_nxt) begin
        last_b_r <= 1'b1;
      end else if (grant_a_nxt) begin
        last_b_r <= 1'b0;
      end
      O_GRANT_A <= grant_a_nxt;
      O_GRANT_B <= grant_b_nxt;
      O_PORT_A_OTHER_WANTS_N <= I_B_REQUEST_N;
      O_PORT_B_OTHER_WANTS_N <= I_A_REQUEST_N;
    end
  end
endmodule

// *** test/drcp_chk_chk.sv ***
// checker on the ports of drcp_top
// assumes one clock and an async low reset
`timescale 1ns/10ps
module drcp_chk(
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CE,
  input wire I_READ_GATE,
  input wire I_SERVO_TICK,
  input wire I_RCVR_TICK,
  input wire I_A_REQUEST_N,
  input wire I_B_REQUEST_N,
  input wire O_DATA,
  input wire O_CLOCK,
  input wire O_PORT_A_OTHER_WANTS_N,
  input wire O_PORT_B_OTHER_WANTS_N,
  input wire O_GRANT_A,
  input wire O_GRANT_B
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  flag_a_a: assert property ($past(I_RST_N) && $past(I_CE) |->
    O_PORT_A_OTHER_WANTS_N == $past(I_B_REQUEST_N)) else $error("flag a");
  flag_b_a: assert property ($past(I_RST_N) && $past(I_CE) |->
    O_PORT_B_OTHER_WANTS_N == $past(I_A_REQUEST_N)) else $error("flag b");
  one_grant_a: assert property (!(O_GRANT_A && O_GRANT_B)) else $error("two");
  grant_hold_a: assert property (O_GRANT_B && !I_B_REQUEST_N |=> O_GRANT_B)
    else $error("lost");
  grant_drop_a: assert property (I_CE && I_A_REQUEST_N |=> !O_GRANT_A)
    else $error("kept");
  grant_give_a: assert property (I_CE && !(O_GRANT_A || O_GRANT_B) && !I_A_REQUEST_N
    && I_B_REQUEST_N |=> O_GRANT_A) else $error("none");
  wclk_src_a: assert property ($changed(O_CLOCK) && !$past(I_READ_GATE) |->
    $past(I_SERVO_TICK)) else $error("wclk");
  rclk_src_a: assert property ($changed(O_CLOCK) && $past(I_READ_GATE) |->
    $past(I_RCVR_TICK)) else $error("rclk");
  data_fall_a: assert property ($changed(O_DATA) |-> $fell(O_CLOCK))
    else $error("data");
endmodule
bind drcp_top drcp_chk drcp_chk_inst(.*);

// *** test/drcp_ctl.sv ***
// controller model: nrz write data on the pair
// assumes wclk is the drive clock, seen on clk
`timescale 1ns/10ps
module drcp_ctl(
  input wire i_clk,
  input wire i_wclk,
  input wire [15:0] i_pat,
  output reg o_data
);
  reg last_r = 0;
  reg [3:0] idx_r = 0;
  initial o_data = 0;
  always @(posedge i_clk) begin
    // a rise is seen one edge late, long before the drive samples again
    if (i_wclk && !last_r) begin
      o_data <= #1 i_pat[idx_r];
      idx_r <= idx_r + 4'h1;
    end
    last_r <= i_wclk;
  end
endmodule

// *** test/tb_drcp_top.sv ***
// bench for drcp_top: write, read, dual access
// assumes drcp_ctl plays the controller
`timescale 1ns/10ps
module tb_drcp_top;
  reg I_CLK = 0, I_RST_N = 0, I_CE = 1, I_WRITE_GATE = 0, I_READ_GATE = 0, I_SERVO_TICK = 0;
  reg I_RCVR_TICK = 0, I_RCVR_BIT = 0, I_A_REQUEST_N = 1, I_B_REQUEST_N = 1, lck = 0;
  wire I_DATA, O_RCVR_READY, O_DATA, O_DATA_OE, O_CLOCK, O_WBIT_VALID, O_WBIT, d;
  wire O_PORT_A_OTHER_WANTS_N, O_PORT_B_OTHER_WANTS_N, O_GRANT_A, O_GRANT_B;
  reg [15:0] pat;
  int failures = 0, checks_done = 0, cyc = 0, nw = 0;
  bit q[$];
  bit pend_r = 0, pbit_r = 0, rd_exp_r = 0;
  // the pair carries whoever drives it
  assign I_DATA = O_DATA_OE ? O_DATA : d;
  always #20 I_CLK = ~I_CLK;
  drcp_ctl drcp_ctl_inst(.i_clk(I_CLK), .i_wclk(O_CLOCK), .i_pat(pat), .o_data(d));
  drcp_top #(.WCLK_DIV(4)) drcp_top_inst(.*);
  // first sampled bit is the controller's idle level, then the pattern in order
  function bit exp_wbit(input int k);
    exp_wbit = (k == 0) ? 1'b0 : pat[4'(k - 1)];
  endfunction
  task chk(input logic s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected %0t: %b not %b", $time, s, e);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cy;
    @(posedge I_CLK) #1;
  endtask
  task rst;
    I_RST_N = 0;
    repeat (3) cy;
    I_RST_N = 1;
    q.delete();
    pend_r = 0;
    rd_exp_r = 0;
  endtask
  always @(posedge I_CLK) if (++cyc == 2000) begin
    failures++;
    test_done;
  end
  // full fifo refuses, so only accepted bits are expected back
  // a bit pushed at the falling edge itself is not yet poppable, so it is held back
  always @(negedge I_CLK) begin
    if (I_READ_GATE && lck && !O_CLOCK) begin
      if (q.size() > 0) rd_exp_r = q.pop_front();
      chk(O_DATA, rd_exp_r);
    end
    if (pend_r) q.push_back(pbit_r);
    pend_r = I_READ_GATE && I_RCVR_TICK && O_RCVR_READY;
    pbit_r = I_RCVR_BIT;
    if (I_WRITE_GATE && O_WBIT_VALID) begin
      chk(O_WBIT, exp_wbit(nw));
      nw++;
    end
    lck = O_CLOCK;
  end
  initial begin
    pat = 16'($urandom(32'hb450d603));
    rst;
    I_WRITE_GATE = 1;
    repeat (300) begin cy; I_SERVO_TICK = 1'($urandom); end
    cy;
    I_SERVO_TICK = 0;
    chk(O_DATA_OE, 1'b0);
    $display("write done");
    I_WRITE_GATE = 0;
    rst;
    I_READ_GATE = 1;
    repeat (300) begin cy; {I_RCVR_TICK, I_RCVR_BIT} = 2'($urandom); end
    cy;
    I_RCVR_TICK = 0;
    chk(O_DATA_OE, 1'b1);
    $display("read done");
    I_READ_GATE = 0;
    {I_A_REQUEST_N, I_B_REQUEST_N} = 2'h0;
    cy;
    chk(O_GRANT_B, 1'b1);
    chk(O_GRANT_A, 1'b0);
    chk(O_PORT_A_OTHER_WANTS_N, 1'b0);
    chk(O_PORT_B_OTHER_WANTS_N, 1'b0);
    if (!O_PORT_B_OTHER_WANTS_N) I_B_REQUEST_N = 1;
    repeat (2) cy;
    chk(O_GRANT_A, 1'b1);
    I_CE = 0;
    I_A_REQUEST_N = 1;
    repeat (3) cy;
    chk(O_GRANT_A, 1'b1);
    chk(O_PORT_B_OTHER_WANTS_N, 1'b0);
    I_CE = 1;
    cy;
    chk(O_GRANT_A, 1'b0);
    chk(O_PORT_B_OTHER_WANTS_N, 1'b1);
    repeat (400) begin cy; {I_A_REQUEST_N, I_B_REQUEST_N} = 2'($urandom); end
    $display("arbiter done");
    test_done;
  end
endmodule
